/* core/bsearch_seq.sv */
// Binary search sequencer with Avalon-MM register slave
`timescale 1ns/1ps
module bsearch_seq
    import bsearch_pkg::*;
#(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Source channel
    output logic signed [W-1:0] src_value,
    output logic [3:0] src_range,
    output logic src_strobe,
    // Synchronous source channel
    output logic signed [W-1:0] sync_value,
    output logic [3:0] sync_range,
    output logic [9:0] sync_chan,
    output logic sync_active,
    // Monitor channel
    output logic meas_req,
    input wire logic meas_ack,
    input wire logic target_above,
    input wire logic target_hit,
    input wire logic target_outside,
    // Abort sources, from outside the clock domain
    input wire logic comp_meas_pin,
    input wire logic comp_other_pin,
    input wire logic adc_ovf_pin,
    input wire logic osc_pin,
    // Interrupt
    output logic irq
);
    // Refuse widths the register bus cannot carry
    if (W < 8 || W > 32) begin : g_bad_width
        $error("W must be 8 to 32");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [31:0] mode_q;            // Mode, abort and post fields
    logic signed [W-1:0] start_q;   // Search start value
    logic signed [W-1:0] stop_q;    // Search stop value
    logic [31:0] sync_q;            // Sync enable, polarity, channel
    logic signed [W-1:0] sync_ofs_q; // Sync offset
    logic [3:0] prim_range_q;       // Primary output range
    logic [W-1:0] resol_q;          // Setting resolution
    logic [ST_NUM-1:0] status_q;    // Sticky events
    logic [ST_NUM-1:0] mask_q;      // Interrupt mask
    logic [2:0] cause_q;            // Search end cause
    logic go;                       // Start request
    logic wr_acc;                   // Write accepted
    logic rd_acc;                   // Read accepted
    logic rd_pend_q;                // Read delay flag
    logic [ST_NUM-1:0] ev_set;      // Events this cycle

    // One wait state on reads, none on writes
    assign avs_waitrequest = avs_read && !rd_pend_q;
    assign wr_acc = avs_write;
    assign rd_acc = avs_read && rd_pend_q;
    assign go = wr_acc && avs_address == OFS_CTRL && avs_writedata[0];

    // Read wait state
    always_ff @(posedge core_clk) begin
        if (!resetn) rd_pend_q <= 1'b0;
        else rd_pend_q <= avs_read && !rd_pend_q;
    end

    // Configuration writes
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mode_q <= MODE_RESET;
            start_q <= '0;
            stop_q <= '0;
            sync_q <= '0;
            sync_ofs_q <= '0;
            prim_range_q <= '0;
            resol_q <= W'(RESOL_RESET);
            mask_q <= '0;
        end else if (wr_acc) begin
            case (avs_address)
                OFS_MODE: mode_q <= avs_writedata & 32'h0000_0331;
                OFS_START: start_q <= avs_writedata[W-1:0];
                OFS_STOP: stop_q <= avs_writedata[W-1:0];
                OFS_SYNC: sync_q <= avs_writedata & 32'h03ff_0003;
                OFS_SYNC_OFS: sync_ofs_q <= avs_writedata[W-1:0];
                OFS_PRIM: begin
                    prim_range_q <= avs_writedata[3:0];
                    sync_q <= '0;
                end
                OFS_MASK: mask_q <= avs_writedata[ST_NUM-1:0];
                OFS_RESOL: resol_q <= avs_writedata[W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Abort input synchronisers
    logic [3:0] ab_s1_q;
    logic [3:0] ab_s2_q;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ab_s1_q <= '0;
            ab_s2_q <= '0;
        end else begin
            ab_s1_q <= {osc_pin, adc_ovf_pin, comp_other_pin, comp_meas_pin};
            ab_s2_q <= ab_s1_q;
        end
    end
    logic abort_en;
    logic abort_hit;
    assign abort_en = mode_q[MODE_ABORT_LSB +: 2] == ABORT_ON;
    assign abort_hit = abort_en && (|ab_s2_q);

    ////////////////////////////////////////////////////////////////////////////
    // Search state machine
    typedef enum {S_IDLE, S_OUT, S_MEAS, S_DONE} state_t;
    state_t st_q;
    logic [1:0] phase_q;            // 0 first point, 1 second, 2 iterate
    logic signed [W-1:0] out_q;     // Present output
    logic signed [W-1:0] step_q;    // Present step magnitude
    logic signed [W-1:0] hit_q;     // Output at target
    logic cautious;
    logic signed [W-1:0] span;
    logic signed [W-1:0] half;
    logic down;                     // Start exceeds stop
    assign cautious = mode_q[MODE_CTL_BIT] == MODE_CAUTIOUS;
    assign down = start_q > stop_q;
    assign span = down ? start_q - stop_q : stop_q - start_q;
    assign half = span >>> 1;

    // Post-search output choice
    // The final output is passed in, since hit_q is loaded on the same edge
    function automatic logic signed [W-1:0] post_val(input logic ab, input logic signed [W-1:0] at);
        if (ab) post_val = start_q;
        else case (mode_q[MODE_POST_LSB +: 2])
            POST_STOP: post_val = stop_q;
            POST_TARGET: post_val = at;
            default: post_val = start_q;
        endcase
    endfunction : post_val

    // Sequencer
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_q <= S_IDLE;
            phase_q <= '0;
            out_q <= '0;
            step_q <= '0;
            hit_q <= '0;
            cause_q <= '0;
            ev_set <= '0;
        end else begin
            ev_set <= '0;
            case (st_q)
                S_IDLE: if (go) begin
                    out_q <= start_q;
                    hit_q <= start_q;
                    phase_q <= 2'd0;
                    cause_q <= '0;
                    st_q <= S_OUT;
                end
                S_OUT: st_q <= S_MEAS;
                S_MEAS: if (abort_hit) begin
                    out_q <= post_val(1'b1, out_q);
                    cause_q <= 3'd1;
                    ev_set <= 3'b011;
                    st_q <= S_DONE;
                end else if (meas_ack) begin
                    if (phase_q == 2'd0) begin
                        phase_q <= 2'd1;
                        step_q <= half;
                        if (cautious) out_q <= down ? start_q - half : start_q + half;
                        else out_q <= stop_q;
                        st_q <= S_OUT;
                    end else if (phase_q == 2'd1 && !cautious && target_outside) begin
                        out_q <= post_val(1'b1, out_q);
                        cause_q <= 3'd2;
                        ev_set <= 3'b101;
                        st_q <= S_DONE;
                    end else if (target_hit) begin
                        hit_q <= out_q;
                        out_q <= post_val(1'b0, out_q);
                        ev_set <= 3'b001;
                        st_q <= S_DONE;
                    end else if (phase_q == 2'd1 && !cautious) begin
                        phase_q <= 2'd2;
                        out_q <= down ? stop_q + half : stop_q - half;
                        st_q <= S_OUT;
                    end else if ((step_q >>> 1) < $signed(resol_q) || step_q == '0) begin
                        hit_q <= out_q;
                        out_q <= post_val(1'b0, out_q);
                        cause_q <= 3'd3;
                        ev_set <= 3'b001;
                        st_q <= S_DONE;
                    end else begin
                        phase_q <= 2'd2;
                        step_q <= step_q >>> 1;
                        out_q <= target_above ? out_q + (step_q >>> 1) : out_q - (step_q >>> 1);
                        st_q <= S_OUT;
                    end
                end
                S_DONE: st_q <= S_IDLE;
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // Source outputs
    assign src_value = out_q;
    assign src_range = prim_range_q;
    assign src_strobe = st_q == S_OUT || st_q == S_DONE;
    assign meas_req = st_q == S_MEAS;

    // Synchronous source follows primary
    always_ff @(posedge core_clk) begin
        if (!resetn) sync_value <= '0;
        else if (sync_q[SYNC_POL_BIT]) sync_value <= out_q + sync_ofs_q;
        else sync_value <= sync_ofs_q - out_q;
    end
    assign sync_range = prim_range_q;
    assign sync_chan = sync_q[SYNC_CH_LSB +: 10];
    assign sync_active = sync_q[SYNC_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Status, interrupt and read data
    logic st_rd;
    assign st_rd = rd_acc && avs_address == OFS_STATUS;
    always_ff @(posedge core_clk) begin
        if (!resetn) status_q <= '0;
        else status_q <= (st_rd ? '0 : status_q) | ev_set;
    end
    assign irq = |(status_q & mask_q);

    // Read multiplexer, registered output
    always_ff @(posedge core_clk) begin
        if (!resetn) avs_readdata <= '0;
        else if (avs_read && !rd_pend_q) begin
            case (avs_address)
                OFS_CTRL: avs_readdata <= {31'h0, st_q != S_IDLE};
                OFS_MODE: avs_readdata <= mode_q;
                OFS_START: avs_readdata <= 32'(start_q);
                OFS_STOP: avs_readdata <= 32'(stop_q);
                OFS_SYNC: avs_readdata <= sync_q;
                OFS_SYNC_OFS: avs_readdata <= 32'(sync_ofs_q);
                OFS_PRIM: avs_readdata <= {28'h0, prim_range_q};
                OFS_STATUS: avs_readdata <= {21'h0, cause_q, 5'h0, status_q};
                OFS_MASK: avs_readdata <= {29'h0, mask_q};
                OFS_RESULT: avs_readdata <= 32'(hit_q);
                OFS_RESOL: avs_readdata <= 32'(resol_q);
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_default_mode: assert property (@(posedge core_clk) $rose(resetn) |-> mode_q[0] == 1'b0)
        else $error("mode not normal after reset");
    chk_abort_ends: assert property (@(posedge core_clk) disable iff (!resetn)
        st_q == S_MEAS && abort_hit |=> st_q == S_DONE && out_q == start_q)
        else $error("abort did not end search at start");
    chk_abort_off: assert property (@(posedge core_clk) disable iff (!resetn)
        st_q == S_MEAS && mode_q[MODE_ABORT_LSB +: 2] != ABORT_ON |=> cause_q != 3'd1)
        else $error("abort active while disabled");
    chk_post_stop: assert property (@(posedge core_clk) disable iff (!resetn)
        st_q == S_MEAS && !abort_hit && meas_ack && target_hit && mode_q[9:8] == POST_STOP
        && !(phase_q == 2'd1 && !cautious && target_outside) && phase_q != 2'd0 |=> out_q == stop_q)
        else $error("post stop value wrong");
    chk_second_point: assert property (@(posedge core_clk) disable iff (!resetn)
        st_q == S_MEAS && !abort_hit && meas_ack && phase_q == 2'd0 && !cautious |=> out_q == stop_q)
        else $error("second output not stop");
    chk_cautious_second: assert property (@(posedge core_clk) disable iff (!resetn)
        st_q == S_MEAS && !abort_hit && meas_ack && phase_q == 2'd0 && cautious && !down
        |=> out_q == $past(start_q) + $past(half))
        else $error("cautious second output wrong");
    chk_step_halves: assert property (@(posedge core_clk) disable iff (!resetn)
        st_q == S_MEAS && phase_q == 2'd2 ##1 st_q == S_OUT |-> step_q == ($past(step_q) >>> 1))
        else $error("step not halved");
    chk_sync_pos: assert property (@(posedge core_clk) disable iff (!resetn)
        sync_q[1] && $stable(sync_q) |=> sync_value == $past(out_q) + $past(sync_ofs_q))
        else $error("sync output wrong");
    chk_sync_clear: assert property (@(posedge core_clk) disable iff (!resetn)
        wr_acc && avs_address == OFS_PRIM |=> sync_q == 32'h0)
        else $error("sync not cleared");
endmodule : bsearch_seq

/* core/bsearch_pkg.sv */
// Package with register map, encodings and field constants of the binary search sequencer
package bsearch_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_START = 8'h08;
    localparam logic [7:0] OFS_STOP = 8'h0c;
    localparam logic [7:0] OFS_SYNC = 8'h10;
    localparam logic [7:0] OFS_SYNC_OFS = 8'h14;
    localparam logic [7:0] OFS_PRIM = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_MASK = 8'h20;
    localparam logic [7:0] OFS_RESULT = 8'h24;
    localparam logic [7:0] OFS_RESOL = 8'h28;
    // Mode register fields
    localparam int MODE_CTL_BIT = 0;
    localparam int MODE_ABORT_LSB = 4;
    localparam int MODE_POST_LSB = 8;
    // Encodings
    localparam logic MODE_NORMAL = 1'b0;
    localparam logic MODE_CAUTIOUS = 1'b1;
    localparam logic [1:0] ABORT_OFF = 2'h1;
    localparam logic [1:0] ABORT_ON = 2'h2;
    localparam logic [1:0] POST_START = 2'h1;
    localparam logic [1:0] POST_STOP = 2'h2;
    localparam logic [1:0] POST_TARGET = 2'h3;
    // Sync register fields
    localparam int SYNC_EN_BIT = 0;
    localparam int SYNC_POL_BIT = 1;
    localparam int SYNC_CH_LSB = 16;
    // Reset values
    localparam logic [31:0] MODE_RESET = 32'h0000_0110;
    localparam logic [31:0] RESOL_RESET = 32'h0000_0001;
    // Status bits
    localparam int ST_DONE = 0;
    localparam int ST_ABORT = 1;
    localparam int ST_RANGE = 2;
    localparam int ST_NUM = 3;
endpackage : bsearch_pkg

/* tb/meas_model.sv */
// Monitor channel model that measures the source output and judges it against a target
`timescale 1ns/1ps
module meas_model (
    // Clock
    input wire logic core_clk,
    // Measurement handshake and verdicts
    input wire logic meas_req,
    input wire logic signed [31:0] src_value,
    output logic meas_ack,
    output logic target_above,
    output logic target_hit,
    output logic target_outside,
    // Scenario setup from the bench
    input wire logic signed [31:0] tgt,
    input wire logic signed [31:0] lo,
    input wire logic signed [31:0] hi,
    input wire logic [7:0] dly
);
    int wait_cnt = 0; // Cycles spent on the current request
    initial meas_ack = 1'b0;
    ////////////////////////////////////////////////////////////////
    // Acknowledge one cycle long, after dly cycles, only while requested
    always @(posedge core_clk) begin
        meas_ack <= 1'b0;
        if (meas_req && !meas_ack) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt >= int'(dly)) begin
                meas_ack <= 1'b1;
                wait_cnt <= 0;
            end
        end else if (!meas_req) begin
            wait_cnt <= 0;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Reading equals the output, so the verdicts follow it directly
    assign target_above = src_value < tgt;
    assign target_hit = src_value == tgt;
    assign target_outside = (tgt < lo && tgt < hi) || (tgt > lo && tgt > hi);
endmodule : meas_model

/* tb/test_bsearch_seq.sv */
// Self-checking bench for the binary search sequencer
`timescale 1ns/1ps
module test_bsearch_seq;
    import bsearch_pkg::*;
    logic core_clk = 1'b0; // 200 MHz clock
    logic resetn = 1'b0; // Held low for 20 cycles
    logic [7:0] avs_address;
    logic avs_read, avs_write;
    logic [31:0] avs_writedata, avs_readdata, r, s;
    logic avs_waitrequest, src_strobe, sync_active, meas_req, meas_ack, irq, irq_b;
    logic signed [31:0] src_value, sync_value, prev, tgt, lo, hi;
    logic [3:0] src_range, sync_range, ab_pins;
    logic [9:0] sync_chan;
    logic t_above, t_hit, t_out;
    logic [7:0] dly;
    logic signed [31:0] seen [$]; // Outputs at each measurement
    int sync_mode = 2; // 0 negative, 1 positive, 2 not checked
    int bad_count = 0;
    int cmp_count = 0;
    int strobe_n = 0; // Strobe cycles in the current search
    always #2.5 core_clk = ~core_clk;
    bsearch_seq i_bsearch_seq (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_value(src_value),
        .src_range(src_range), .src_strobe(src_strobe), .sync_value(sync_value),
        .sync_range(sync_range), .sync_chan(sync_chan), .sync_active(sync_active),
        .meas_req(meas_req), .meas_ack(meas_ack), .target_above(t_above), .target_hit(t_hit),
        .target_outside(t_out), .comp_meas_pin(ab_pins[0]), .comp_other_pin(ab_pins[1]),
        .adc_ovf_pin(ab_pins[2]), .osc_pin(ab_pins[3]), .irq(irq));
    meas_model i_meas_model (.core_clk(core_clk), .meas_req(meas_req), .src_value(src_value),
        .meas_ack(meas_ack), .target_above(t_above), .target_hit(t_hit),
        .target_outside(t_out), .tgt(tgt), .lo(lo), .hi(hi), .dly(dly));
    ////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
        cmp_count++;
        if (v !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, v);
        end
    endtask : chk
    // Avalon write, held until waitrequest is sampled low
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    // Avalon read, data taken at the edge where waitrequest is low
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask : rd
    // Mode word from control mode, abort and post fields
    function automatic logic [31:0] mw(input logic m, input logic [1:0] a, input logic [1:0] p);
        return {22'h0, p, 2'h0, a, 3'h0, m};
    endfunction : mw
    // Run one search, raise abort pins after 60 cycles, return status
    task automatic search(input logic [31:0] st, sp, tg, md, input logic [3:0] pm);
        int n;
        seen.delete();
        strobe_n = 0;
        tgt <= tg;
        lo <= st;
        hi <= sp;
        wr(OFS_START, st);
        wr(OFS_STOP, sp);
        wr(OFS_MODE, md);
        wr(OFS_CTRL, 32'h1);
        repeat (60) @(posedge core_clk);
        ab_pins <= pm;
        n = 0;
        do begin
            rd(OFS_CTRL, r);
            n++;
        end while (r[0] !== 1'b0 && n < 400);
        chk("busy", 32'h0, {31'h0, r[0]});
        ab_pins <= 4'h0;
        irq_b = irq;
        rd(OFS_STATUS, s);
        @(posedge core_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        chk("strobe idle", 32'h0, {31'h0, src_strobe});
        $display("search from %0d to %0d target %0d done", st, sp, tg);
    endtask : search
    // Compare the recorded outputs with the expected walk
    task automatic ckseq(input int n, input logic [31:0] e [5]);
        chk("meas count", 32'(n), 32'(seen.size()));
        chk("strobe count", 32'(n + 1), 32'(strobe_n));
        for (int i = 0; i < n && i < seen.size(); i++) chk("output", e[i], seen[i]);
    endtask : ckseq
    // Verdict and end of run
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////
    // Record outputs at each measurement and follow the sync source
    always @(posedge core_clk) begin
        if (meas_ack) seen.push_back(src_value);
        if (src_strobe) strobe_n <= strobe_n + 1;
        if (sync_mode < 2) chk("sync value", sync_mode ? prev + 100 : 100 - prev, sync_value);
        prev <= src_value;
    end
    // Watchdog: ten searches of under 150 cycles each
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        ab_pins = 4'h0;
        tgt = 0;
        lo = 0;
        hi = 0;
        dly = 8'h00;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        rd(OFS_MODE, r); chk("mode reset", MODE_RESET, r);
        rd(OFS_RESOL, r); chk("resol reset", RESOL_RESET, r);
        wr(8'h3c, 32'h5); rd(8'h3c, r); chk("unmapped", 32'h0, r);
        wr(OFS_MASK, 32'h1);
        wr(OFS_PRIM, 32'h3);
        wr(OFS_SYNC, 32'h0005_0001);
        wr(OFS_SYNC_OFS, 32'd100);
        sync_mode <= 0;
        $display("register test done");
        // Normal mode, prompt answers, stay at the hit output
        search(0, 64, 40, mw(MODE_NORMAL, ABORT_OFF, POST_TARGET), 4'h0);
        ckseq(5, '{32'd0, 32'd64, 32'd32, 32'd48, 32'd40});
        chk("post target", 32'd40, src_value);
        chk("done status", 32'h1, {26'h0, s[10:8], s[2:0]});
        chk("irq", 32'h1, {31'h0, irq_b});
        rd(OFS_RESULT, r); chk("result", 32'd40, r);
        chk("sync chan", 32'd5, {22'h0, sync_chan});
        chk("src range", 32'h3, {28'h0, src_range});
        chk("sync range", 32'h3, {28'h0, sync_range});
        chk("sync active", 32'h1, {31'h0, sync_active});
        // Start above stop, slow answers, positive sync
        sync_mode <= 2;
        dly <= 8'd20;
        wr(OFS_SYNC, 32'h0005_0003);
        repeat (2) @(posedge core_clk);
        sync_mode <= 1;
        search(64, 0, 40, mw(MODE_NORMAL, ABORT_OFF, POST_STOP), 4'h0);
        ckseq(5, '{32'd64, 32'd0, 32'd32, 32'd48, 32'd40});
        chk("post stop", 32'd0, src_value);
        sync_mode <= 2;
        wr(OFS_PRIM, 32'h3);
        rd(OFS_SYNC, r); chk("sync cleared", 32'h0, r);
        chk("sync inactive", 32'h0, {31'h0, sync_active});
        // Cautious mode
        search(0, 64, 40, mw(MODE_CAUTIOUS, ABORT_OFF, POST_START), 4'h0);
        ckseq(4, '{32'd0, 32'd32, 32'd48, 32'd40, 32'd0});
        chk("post start", 32'd0, src_value);
        // Target outside the span
        search(0, 64, 100, mw(MODE_NORMAL, ABORT_OFF, POST_TARGET), 4'h0);
        ckseq(2, '{32'd0, 32'd64, 32'd0, 32'd0, 32'd0});
        chk("outside start", 32'd0, src_value);
        chk("outside cause", 32'h0a, {27'h0, s[10:8], s[2:1]});
        // Resolution stop with no post setting
        wr(OFS_RESOL, 32'd16);
        search(0, 64, 41, mw(MODE_NORMAL, ABORT_OFF, 2'h0), 4'h0);
        ckseq(4, '{32'd0, 32'd64, 32'd32, 32'd48, 32'd0});
        chk("unset post", 32'd0, src_value);
        chk("resol cause", 32'h0c, {27'h0, s[10:8], s[2:1]});
        wr(OFS_RESOL, 32'd1);
        // Abort disabled: an oscillation does not stop the search
        search(8, 72, 48, mw(MODE_NORMAL, ABORT_OFF, POST_TARGET), 4'h8);
        ckseq(5, '{32'd8, 32'd72, 32'd40, 32'd56, 32'd48});
        // Abort enabled: each cause stops it and returns to start
        for (int i = 0; i < 4; i++) begin
            search(8, 72, 48, mw(MODE_NORMAL, ABORT_ON, POST_TARGET), 4'(4'h1 << i));
            chk("abort start", 32'd8, src_value);
            chk("abort cause", 32'h05, {27'h0, s[10:8], s[2:1]});
        end
        give_verdict();
    end
endmodule : test_bsearch_seq
